// File: verilog/pll_core_clock.sv
`timescale 1ns/1ps
module pll_core_clock
    import pll_pkg::*;
#(
    parameter int LOCK_COUNT = LOCK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ref_clock_in,
    input wire logic [1:0] ratio_select_pins,
    input wire logic reset_pin_n,
    output logic core_tick,
    output logic periph_tick,
    output logic core_reset_n,
    output logic pll_locked,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic rst_meta;
    logic rst_n;
    logic [31:0] power_mgmt_control_reg;
    logic [31:0] aw_addr;
    logic aw_got;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic ref_q;
    logic ref_rise;
    logic [5:0] loop_multiplier;
    logic [1:0] loop_post_divider;
    logic input_halve_enable;
    logic [5:0] pin_mult;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic [ACC_W-1:0] add_step;
    logic [ACC_W-1:0] sub_step;
    logic core_fire;
    logic periph_phase;
    logic [31:0] lock_cnt;
    logic [5:0] last_mult;
    logic [1:0] last_div;
    logic last_halve;
    release_state_type rel_state;
    logic [12:0] ref_cnt;
    logic [1:0] core_cnt;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_comb begin
        case (ratio_select_pins)
            2'h0: pin_mult = RATIO_SEL_00;
            2'h1: pin_mult = RATIO_SEL_01;
            2'h2: pin_mult = RATIO_SEL_10;
            default: pin_mult = RATIO_SEL_11;
        endcase
    end

    assign loop_multiplier = power_mgmt_control_reg[MULT_LSB +: MULT_W];
    assign loop_post_divider =
        power_mgmt_control_reg[POSTDIV_LSB +: POSTDIV_W];
    assign input_halve_enable = power_mgmt_control_reg[HALVE_BIT];

    // write channels are taken independently, answered once both are held
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_got <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_got <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == {28'h0, ADDR_CONTROL} ||
                    aw_addr == {28'h0, ADDR_STATUS}) ?
                    RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // pins own the ratio while the device reset pin is low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            power_mgmt_control_reg <= CONTROL_RESET;
        end else if (!reset_pin_n) begin
            power_mgmt_control_reg[MULT_LSB +: MULT_W] <=
                pin_mult;
            power_mgmt_control_reg[POSTDIV_LSB +: POSTDIV_W] <=
                2'h0;
        end else if (aw_got && w_got && !s_axi_bvalid &&
                     aw_addr[31:0] == {28'h0, ADDR_CONTROL}) begin
            for (int i = 0; i < 2; i++) begin
                if (w_strb[i]) begin
                    power_mgmt_control_reg[i*8 +: 8] <=
                        w_data[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == {28'h0, ADDR_CONTROL}) begin
                s_axi_rdata <= {23'h0, power_mgmt_control_reg[8:0]};
            end else if (s_axi_araddr == {28'h0, ADDR_STATUS}) begin
                s_axi_rdata <= {18'h0, loop_multiplier, 6'h0,
                    core_reset_n, pll_locked};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // reference is sampled by clk_sys, so it must run well below 125 MHz
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= ref_clock_in;
        end
    end
    assign ref_rise = ref_clock_in && !ref_q;

    // oscillator cycles per reference edge: 2*M, or M with the halver on
    assign add_step = ref_rise ? (input_halve_enable ?
        {{(ACC_W-6){1'b0}}, loop_multiplier} :
        {{(ACC_W-7){1'b0}}, loop_multiplier, 1'b0}) : '0;
    // oscillator cycles per core cycle: 2*D with D = 1, 2, 4 or 8
    assign sub_step = {{(ACC_W-5){1'b0}},
        5'(5'h02 << loop_post_divider)};
    assign core_fire = pll_locked && (acc >= sub_step);
    // core ticks are at most one per clk_sys; faster settings saturate
    assign next_acc = acc + add_step - (core_fire ? sub_step : '0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc <= '0;
            core_tick <= 1'b0;
            periph_tick <= 1'b0;
            periph_phase <= 1'b0;
        end else begin
            if (!pll_locked) begin
                acc <= '0;
            end else if (!next_acc[ACC_W-1]) begin
                // a saturated accumulator holds instead of wrapping round
                acc <= next_acc;
            end
            core_tick <= core_fire;
            periph_tick <= core_fire && periph_phase;
            if (core_fire) begin
                periph_phase <= !periph_phase;
            end
        end
    end

    // relock after any change of loop settings
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt <= 32'h0000_0000;
            pll_locked <= 1'b0;
            last_mult <= 6'h00;
            last_div <= 2'h0;
            last_halve <= 1'b0;
        end else begin
            last_mult <= loop_multiplier;
            last_div <= loop_post_divider;
            last_halve <= input_halve_enable;
            if (last_mult != loop_multiplier || last_div != loop_post_divider
                || last_halve != input_halve_enable) begin
                lock_cnt <= 32'h0000_0000;
                pll_locked <= 1'b0;
            end else if (lock_cnt >= 32'(LOCK_COUNT - 1)) begin
                pll_locked <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rel_state <= REL_HOLD;
            ref_cnt <= 13'h0000;
            core_cnt <= 2'h0;
            core_reset_n <= 1'b0;
        end else if (!reset_pin_n) begin
            rel_state <= REL_HOLD;
            ref_cnt <= 13'h0000;
            core_cnt <= 2'h0;
            core_reset_n <= 1'b0;
        end else begin
            case (rel_state)
                REL_HOLD: begin
                    rel_state <= REL_COUNT_REF;
                end
                REL_COUNT_REF: begin
                    // edge sampling may cost one extra reference cycle
                    if (ref_rise) begin
                        ref_cnt <= ref_cnt + 13'h0001;
                        if (ref_cnt == CORE_RST_REF_CYCLES - 13'h0001) begin
                            rel_state <= REL_COUNT_CORE;
                        end
                    end
                end
                REL_COUNT_CORE: begin
                    if (core_fire) begin
                        core_cnt <= core_cnt + 2'h1;
                        if (core_cnt == CORE_RST_CORE_CYCLES - 2'h1) begin
                            rel_state <= REL_RUN;
                            core_reset_n <= 1'b1;
                        end
                    end
                end
                REL_RUN: begin
                    core_reset_n <= 1'b1;
                end
                default: begin
                    rel_state <= REL_HOLD;
                end
            endcase
        end
    end
endmodule : pll_core_clock

// File: verilog/pll_pkg.sv
package pll_pkg;
    // register byte addresses
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    // control register fields
    localparam int MULT_LSB = 0;
    localparam int MULT_W = 6;
    localparam int POSTDIV_LSB = 6;
    localparam int POSTDIV_W = 2;
    localparam int HALVE_BIT = 8;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0008;
    // status register fields
    localparam int STAT_LOCKED_BIT = 0;
    localparam int STAT_CORE_RUN_BIT = 1;
    localparam int STAT_MULT_LSB = 8;
    // multiplier chosen by the ratio select pins while held in reset
    localparam logic [5:0] RATIO_SEL_00 = 6'h08;
    localparam logic [5:0] RATIO_SEL_01 = 6'h20;
    localparam logic [5:0] RATIO_SEL_10 = 6'h10;
    localparam logic [5:0] RATIO_SEL_11 = 6'h08;
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int LOCK_TIME_US = 100;
    localparam int LOCK_CYCLES = (LOCK_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam logic [12:0] CORE_RST_REF_CYCLES = 13'h1000;
    localparam logic [1:0] CORE_RST_CORE_CYCLES = 2'h2;
    localparam int ACC_W = 16;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        REL_HOLD,
        REL_COUNT_REF,
        REL_COUNT_CORE,
        REL_RUN
    } release_state_type;
endpackage : pll_pkg

// File: verif/ref_source.sv
`timescale 1ns/1ps
module ref_source #(
    parameter int HALF = 4,
    parameter int SETTLE = 5000
) (
    input wire logic clk_sys,
    input wire logic want_run,
    input wire logic [1:0] want_ratio,
    output logic ref_clock_in = 1'b0,
    output logic [1:0] ratio_select_pins = 2'h0,
    output logic reset_pin_n = 1'b0
);
    int ph = 0;
    int low_refs = 0;
    int quiet = 0;
    // free running from power-up so it has long settled at any release
    always @(posedge clk_sys) begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1) ref_clock_in <= !ref_clock_in;
    end
    always @(posedge clk_sys) begin
        quiet <= (want_ratio != ratio_select_pins) ? 0 : quiet + 1;
        if (!reset_pin_n) ratio_select_pins <= want_ratio;
        if (!reset_pin_n && ph == HALF - 1 && !ref_clock_in)
            low_refs <= low_refs + 1;
        if (!want_run) begin
            reset_pin_n <= 1'b0;
            low_refs <= 0;
        end else if (low_refs >= 4 && quiet >= SETTLE)
            reset_pin_n <= 1'b1;
    end
endmodule : ref_source

// File: verif/pll_chk.sv
`timescale 1ns/1ps
module pll_chk (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ref_clock_in,
    input wire logic reset_pin_n,
    input wire logic core_tick,
    input wire logic periph_tick,
    input wire logic core_reset_n,
    input wire logic pll_locked,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    logic phase;
    logic [12:0] rises;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) phase <= 1'b0;
        else if (core_tick) phase <= !phase;
    end
    // counts from the pin release, so hold and tail cycles may add one each
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) rises <= 13'h0000;
        else if (!reset_pin_n) rises <= 13'h0000;
        else if ($rose(ref_clock_in) && rises != 13'h1FFF)
            rises <= rises + 13'h0001;
    end
    tick_lock_a: assert property (core_tick |-> $past(pll_locked))
        else $error("core tick without lock");
    periph_phase_a: assert property (
        periph_tick == (core_tick && phase))
        else $error("peripheral tick out of phase");
    pin_holds_core_a: assert property (
        !reset_pin_n |=> !core_reset_n)
        else $error("core reset released while pin low");
    release_count_a: assert property (
        $rose(core_reset_n) |-> rises inside {[4096:4098]})
        else $error("core reset released at wrong count");
    release_tick_a: assert property (
        $rose(core_reset_n) |-> core_tick)
        else $error("core reset not on a core tick");
    write_busy_a: assert property (
        s_axi_bvalid |-> !s_axi_awready)
        else $error("write address ready during response");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_busy_a: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready during response");
    cover property ($rose(core_reset_n));
    cover property ($rose(pll_locked));
    cover property (periph_tick);
endmodule : pll_chk
bind pll_core_clock pll_chk u_chk (.*);

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pll_pkg::*;
    logic clk_sys = 1'b0, resetn = 1'b0, want_run = 1'b0;
    logic [1:0] want_ratio = 2'h0, ratio_select_pins, s_axi_bresp, s_axi_rresp;
    logic ref_clock_in, reset_pin_n, core_tick, periph_tick, core_reset_n;
    logic pll_locked, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [5:0] pin_tab [4] = '{RATIO_SEL_00, RATIO_SEL_01, RATIO_SEL_10,
        RATIO_SEL_11};
    int mismatches = 0, tests_run = 0, ncore = 0, nper = 0;
    always #2 clk_sys = !clk_sys;
    ref_source #(.HALF(4), .SETTLE(64)) src (.*);
    pll_core_clock #(.LOCK_COUNT(20)) uut (.*);
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic near(input string nm, input int e, input int g,
        input int tol);
        tests_run++;
        if (g < e - tol || g > e + tol) begin
            mismatches++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : near
    task automatic hang(input string nm);
        mismatches++;
        $display("ERROR %s expected answer seen timeout", nm);
        close_out();
    endtask : hang
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 50) hang("write");
        chk("bresp", RESP_OKAY, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [31:0] a, input logic [31:0] e,
        input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 50) hang("read");
        chk("rdata", e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'b0;
    endtask : rdc
    function automatic int rate(input int m, input int sel, input bit hv);
        int t;
        t = 100 * (hv ? m : 2 * m) /
            (2 * (1 << sel));
        return (t > 800) ? 800 : t;
    endfunction : rate
    always @(posedge clk_sys) begin
        if (core_tick === 1'b1) ncore <= ncore + 1;
        if (periph_tick === 1'b1) nper <= nper + 1;
    end
    initial begin
        int n, m, sel, c0, p0, e;
        bit hv;
        void'($urandom(41283));
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdc(ADDR_CONTROL, CONTROL_RESET, RESP_OKAY);
        for (n = 0; n < 4; n++) begin
            want_ratio <= n[1:0];
            repeat (4) @(posedge clk_sys);
            wr(ADDR_CONTROL, 32'h0000_00C5);
            rdc(ADDR_CONTROL, {26'h0, pin_tab[n]},
                RESP_OKAY);
        end
        rdc(32'h0000_0008, 32'h0, RESP_SLVERR);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        want_ratio <= 2'h0;
        want_run <= 1'b1;
        // a pin pulse mid-count must restart the whole release count
        for (n = 0; n < 9000 && reset_pin_n !== 1'b1; n++) @(posedge clk_sys);
        if (n == 9000) hang("pin release");
        repeat (1000) @(posedge clk_sys);
        want_run <= 1'b0;
        repeat (2) @(posedge clk_sys);
        want_run <= 1'b1;
        for (n = 0; n < 9000 && reset_pin_n !== 1'b1; n++) @(posedge clk_sys);
        if (n == 9000) hang("pin release");
        for (n = 0; n < 40000 && core_reset_n !== 1'b1; n++)
            @(posedge clk_sys);
        near("core release", 4096 * 8, n, 16);
        if (n == 40000) hang("core release");
        // bits above bit 8 do not read back; the low byte stays a legal loop setting
        wr(ADDR_CONTROL, 32'hFFFF_FE0C);
        rdc(ADDR_CONTROL, 32'h0000_000C, RESP_OKAY);
        for (n = 0; n < 7; n++) begin
            // multipliers up to 12 can pass the one tick per clk_sys ceiling; rate caps them at 800
            m = (n == 0) ? 1 : 1 + $urandom % 12;
            sel = (n == 0) ? 3 : $urandom % 4;
            hv = (n == 0) ? 1'b1 : 1'($urandom % 2);
            wr(ADDR_CONTROL, {23'h0, hv, sel[1:0], m[5:0]});
            repeat (4) @(posedge clk_sys);
            for (e = 0; e < 200 && pll_locked !== 1'b1; e++)
                @(posedge clk_sys);
            if (e == 200) hang("lock");
            rdc(ADDR_STATUS, {18'h0, m[5:0], 6'h0, 2'h3},
                RESP_OKAY);
            c0 = ncore;
            p0 = nper;
            repeat (800) @(posedge clk_sys);
            e = rate(m, sel, hv);
            near("core ticks", e, ncore - c0,
                e / 100 + 3);
            near("periph ticks", e / 2, nper - p0, e / 200 + 2);
        end
        close_out();
    end
endmodule : tb_top
